// ### tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ext_count_i = 1'b0;
    logic cmp_a_dir_i = 1'b1;
    logic cmp_b_dir_i = 1'b0;
    logic cmp_a_vector_ack_i = 1'b0;
    logic cmp_b_vector_ack_i = 1'b0;
    logic ovf_vector_ack_i = 1'b0;
    logic [7:0] rdata_o;
    logic cmp_a_out_o, cmp_a_pin_oe_n_o, cmp_a_override_o, cmp_b_out_o, cmp_b_pin_oe_n_o;
    logic cmp_b_override_o, cmp_a_flag_o, cmp_b_flag_o, overflow_flag_o;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] q, q2;

    tmr_core i_tmr_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_count_i(ext_count_i),
        .cmp_a_dir_i(cmp_a_dir_i), .cmp_b_dir_i(cmp_b_dir_i),
        .cmp_a_vector_ack_i(cmp_a_vector_ack_i), .cmp_b_vector_ack_i(cmp_b_vector_ack_i),
        .ovf_vector_ack_i(ovf_vector_ack_i), .cmp_a_out_o(cmp_a_out_o),
        .cmp_a_pin_oe_n_o(cmp_a_pin_oe_n_o), .cmp_a_override_o(cmp_a_override_o),
        .cmp_b_out_o(cmp_b_out_o), .cmp_b_pin_oe_n_o(cmp_b_pin_oe_n_o),
        .cmp_b_override_o(cmp_b_override_o), .cmp_a_flag_o(cmp_a_flag_o),
        .cmp_b_flag_o(cmp_b_flag_o), .overflow_flag_o(overflow_flag_o));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task finish_test;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task t_regs;
        rd(ADDR_CTRL_B, q);
        chk("ctrl_b reset", 16'h0000, {8'h00, q});
        wr(ADDR_CTRL_A, 8'hff);
        rd(ADDR_CTRL_A, q);
        chk("ctrl_a", 16'h00f3, {8'h00, q});
        chk("pin a enable", 16'h0002, {14'h0, cmp_a_override_o, cmp_a_pin_oe_n_o});
        cmp_b_dir_i <= 1'b1;
        wr(ADDR_CTRL_B, 8'h38);
        rd(ADDR_CTRL_B, q);
        chk("ctrl_b", 16'h0008, {8'h00, q});
        chk("pin b enable", 16'h0000, {15'h0, cmp_b_pin_oe_n_o});
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_COUNTER, 8'h5a);
        rd(ADDR_COUNTER, q);
        chk("counter", 16'h005a, {8'h00, q});
        rd(3'h7, q);
        chk("unmapped", 16'h0000, {8'h00, q});
    endtask

    task t_force;
        logic [1:0] fc [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
        logic fe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        wr(ADDR_CMP_B, 8'h20);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_A, {fc[i], fc[i], 4'h0});
            wr(ADDR_CTRL_B, 8'hc0);
            @(posedge clk_i);
            #1 chk("forced out", {15'h0, fe[i]}, {15'h0, cmp_b_out_o});
            chk("forced out a", {15'h0, fe[i]}, {15'h0, cmp_a_out_o});
        end
        rd(ADDR_FLAGS, q);
        chk("flags after force", 16'h0000, {8'h00, q});
    endtask

    task t_match;
        wr(ADDR_COUNTER, 8'h1f);
        wr(ADDR_CTRL_B, 8'h01);
        repeat (10) @(posedge clk_i);
        chk("toggle out", 16'h0001, {15'h0, cmp_b_out_o});
        rd(ADDR_FLAGS, q);
        chk("flag b set", 16'h0002, {8'h00, q & 8'h03});
        wr(ADDR_FLAGS, 8'h02);
        rd(ADDR_FLAGS, q);
        chk("flag b cleared", 16'h0000, {8'h00, q & 8'h03});
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_COUNTER, 8'h20);
        wr(ADDR_CTRL_B, 8'h01);
        repeat (10) @(posedge clk_i);
        chk("blocked out", 16'h0001, {15'h0, cmp_b_out_o});
        rd(ADDR_FLAGS, q);
        chk("blocked flag", 16'h0000, {8'h00, q & 8'h03});
        repeat (260) @(posedge clk_i);
        chk("wrap flags", 16'h0007, {13'h0, cmp_a_flag_o, cmp_b_flag_o, overflow_flag_o});
        cmp_b_vector_ack_i <= 1'b1;
        ovf_vector_ack_i <= 1'b1;
        @(posedge clk_i);
        cmp_b_vector_ack_i <= 1'b0;
        ovf_vector_ack_i <= 1'b0;
        #1 chk("acked flags", 16'h0004, {13'h0, cmp_a_flag_o, cmp_b_flag_o, overflow_flag_o});
    endtask

    // read spacing is gap plus two cycles, a whole multiple of each prescaler tap
    task t_rate;
        logic [2:0] cs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
        int gap [6] = '{18, 18, 62, 126, 510, 1022};
        logic [7:0] dif [6] = '{8'h00, 8'h14, 8'h08, 8'h02, 8'h02, 8'h01};
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_CTRL_B, {5'h0, cs[i]});
            rd(ADDR_COUNTER, q);
            repeat (gap[i]) @(posedge clk_i);
            rd(ADDR_COUNTER, q2);
            chk("count rate", {8'h00, dif[i]}, {8'h00, q2 - q});
        end
    endtask

    task t_ext;
        for (int s = 6; s < 8; s++) begin
            wr(ADDR_CTRL_B, 8'(s));
            rd(ADDR_COUNTER, q);
            repeat (3) begin
                ext_count_i <= 1'b1;
                repeat (4) @(posedge clk_i);
                ext_count_i <= 1'b0;
                repeat (4) @(posedge clk_i);
            end
            rd(ADDR_COUNTER, q2);
            chk("ext count", 16'h0003, {8'h00, q2 - q});
        end
    endtask

    task t_pwm;
        logic [1:0] wm [4] = '{2'h3, 2'h3, 2'h1, 2'h1};
        logic [1:0] cd [4] = '{2'h2, 2'h3, 2'h2, 2'h3};
        int per [4] = '{256, 256, 510, 510};
        int exp_hi [4] = '{65, 191, 128, 382};
        int h;
        wr(ADDR_CMP_B, 8'h40);
        wr(ADDR_CTRL_B, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_A, {2'h0, cd[i], 2'h0, wm[i]});
            repeat (600) @(posedge clk_i);
            h = 0;
            repeat (per[i]) begin
                @(negedge clk_i);
                h += int'(cmp_b_out_o);
            end
            chk("high cycles", 16'(exp_hi[i]), 16'(h));
        end
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_regs;
        t_force;
        t_match;
        t_rate;
        t_ext;
        t_pwm;
        finish_test;
    end
endmodule // tb

// ### tmr_core.sv
// Operation
// (R1) nonzero output mode b connects compare_b_output to pin; driver needs direction bit
// (R2) non-PWM modes: code 0 off, 1 toggle, 2 clear, 3 set on match
// (R3) fast PWM: 2 clear on match set at TOP, 3 opposite, 1 reserved
// (R4) phase correct: 2 clear up-match set down-match, 3 opposite, 1 reserved
// (R5) compare equal TOP with upper mode bit: ignore match, act at TOP
// (R6) control a bits 3,2 and control b bits 5,4 read zero
// (R7) waveform mode is hi bit with two lo bits
// (R8) mode decode gives TOP source and waveform type; 4 and 6 reserved
// (R9) overflow at MAX in 0,2,3, BOTTOM in phase correct, TOP in 7
// (R10) compare registers immediate in 0 and 2, buffered to TOP in PWM
// (R11) force strobes act in non-PWM only, apply output mode, read zero
// (R12) force strobe sets no flag and never clears counter
// (R13) software writes zero force bits while in PWM mode
// (R14) clock select: stop, div 1, 8, 64, 256, 1024, ext fall, ext rise
// (R15) external edges count even when the pin is an output
// (R16) counter register readable and writable by software
// (R17) counter write suppresses compare match on next timer enable
// (R18) software avoids writing counter while it runs
// (R19) compare b value compared continuously with counter
// (R20) compare b flag sets on match, clears by vector ack or one written
// (R21) all updates on I/O clock qualified by one-cycle timer enable
//
// Implementation choices: the register addresses and the plain strobed port.
module tmr_core
    import tmr_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [tmr_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic ext_count_i,
    input wire logic cmp_a_dir_i,
    input wire logic cmp_b_dir_i,
    input wire logic cmp_a_vector_ack_i,
    input wire logic cmp_b_vector_ack_i,
    input wire logic ovf_vector_ack_i,
    output logic cmp_a_out_o,
    output logic cmp_a_pin_oe_n_o,
    output logic cmp_a_override_o,
    output logic cmp_b_out_o,
    output logic cmp_b_pin_oe_n_o,
    output logic cmp_b_override_o,
    output logic cmp_a_flag_o,
    output logic cmp_b_flag_o,
    output logic overflow_flag_o
);
    import tmr_pkg::*;

    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] count;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_a_act;
    logic [7:0] cmp_b_act;
    logic count_down;
    logic block_match;
    logic out_a;
    logic out_b;
    logic flag_a;
    logic flag_b;
    logic flag_ovf;
    logic [PRESC_W-1:0] presc;
    logic [2:0] ext_sync;
    logic ext_lvl;
    logic ext_rise;
    logic ext_fall;
    logic [1:0] com_a;
    logic [1:0] com_b;
    tmr_wave_mode_t wmode;
    tmr_clk_sel_t csel;
    logic tick;
    logic is_pwm;
    logic is_fast;
    logic is_pc;
    logic [7:0] top;
    logic at_top;
    logic match_a;
    logic match_b;
    logic wr_count;
    logic force_a;
    logic force_b;
    logic ovf_event;
    logic [7:0] next_count;
    logic next_down;

    assign com_a = ctrl_a[CA_COM_A_POS +: 2];
    assign com_b = ctrl_a[CA_COM_B_POS +: 2];
    assign wmode = tmr_wave_mode_t'({ctrl_b[CB_WGM_HI_POS], ctrl_a[CA_WGM_LO_POS +: 2]}); // R7
    assign csel = tmr_clk_sel_t'(ctrl_b[CB_CS_POS +: 3]);
    assign wr_count = wr_i && (addr_i == ADDR_COUNTER);

    // mode decode
    always_comb begin // R8
        is_fast = 1'b0;
        is_pc = 1'b0;
        top = VAL_MAX;
        case (wmode)
            WM_NORMAL: top = VAL_MAX;
            WM_PC_FF: is_pc = 1'b1;
            WM_CTC: top = cmp_a_act;
            WM_FAST_FF: is_fast = 1'b1;
            WM_PC_OCRA: begin
                is_pc = 1'b1;
                top = cmp_a_act;
            end
            WM_FAST_OCRA: begin
                is_fast = 1'b1;
                top = cmp_a_act;
            end
            default: top = VAL_MAX; // reserved modes run as normal
        endcase
    end
    assign is_pwm = is_fast | is_pc;
    assign at_top = (count == top);

    // free-running prescaler shared by all taps: the first count after enabling may come early
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            presc <= '0;
        end else begin
            presc <= presc + 1'b1;
        end
    end

    // pin passes three flops; a new level counts only once the second and third agree,
    // so a glitch caught by the first stage never reaches the counter
    always_ff @(posedge clk_i or negedge reset_n_i) begin // R15
        if (!reset_n_i) begin
            ext_sync <= 3'h0;
            ext_lvl <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_count_i};
            if (ext_sync[2] == ext_sync[1]) begin
                ext_lvl <= ext_sync[2];
            end
        end
    end
    assign ext_rise = ext_sync[2] & ext_sync[1] & ~ext_lvl;
    assign ext_fall = ~ext_sync[2] & ~ext_sync[1] & ext_lvl;

    always_comb begin // R14 R21
        case (csel)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (presc[$clog2(DIV_8)-1:0] == '1);
            CS_DIV64: tick = (presc[$clog2(DIV_64)-1:0] == '1);
            CS_DIV256: tick = (presc[$clog2(DIV_256)-1:0] == '1);
            CS_DIV1024: tick = (presc[$clog2(DIV_1024)-1:0] == '1);
            CS_EXT_FALL: tick = ext_fall;
            CS_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    // matches; a counter write blocks the match on the following tick
    assign match_a = tick && !block_match && (count == cmp_a_act); // R17
    assign match_b = tick && !block_match && (count == cmp_b_act); // R19
    assign force_a = wr_i && (addr_i == ADDR_CTRL_B) && wdata_i[CB_FOC_A_POS] && !is_pwm; // R11
    assign force_b = wr_i && (addr_i == ADDR_CTRL_B) && wdata_i[CB_FOC_B_POS] && !is_pwm; // R11

    always_comb begin // R9
        case (wmode)
            WM_PC_FF, WM_PC_OCRA: ovf_event = tick && count_down && (count == VAL_BOTTOM);
            WM_FAST_OCRA: ovf_event = tick && at_top;
            default: ovf_event = tick && (count == VAL_MAX);
        endcase
    end

    // counting sequence
    always_comb begin
        next_count = count;
        next_down = count_down;
        if (is_pc) begin
            if (!count_down && at_top) begin
                next_down = 1'b1;
                next_count = count - 1'b1;
            end else if (count_down && count == VAL_BOTTOM) begin
                next_down = 1'b0;
                next_count = count + 1'b1;
            end else begin
                next_count = count_down ? count - 1'b1 : count + 1'b1;
            end
        end else begin
            next_down = 1'b0;
            // only a real match at TOP clears, never a forced one
            next_count = (at_top && wmode != WM_NORMAL) ? VAL_BOTTOM : count + 1'b1; // R12
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin // R16
        if (!reset_n_i) begin
            count <= COUNTER_RESET;
            count_down <= 1'b0;
        end else if (wr_count) begin
            count <= wdata_i;
        end else if (tick) begin
            count <= next_count;
            count_down <= next_down;
        end
    end

    // held through stopped periods until the counter really steps
    always_ff @(posedge clk_i or negedge reset_n_i) begin // R17
        if (!reset_n_i) begin
            block_match <= 1'b0;
        end else if (wr_count) begin
            block_match <= 1'b1;
        end else if (tick) begin
            block_match <= 1'b0;
        end
    end

    // control and compare buffers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_a <= CTRL_A_RESET;
            ctrl_b <= CTRL_B_RESET;
            cmp_a_buf <= CMP_RESET;
            cmp_b_buf <= CMP_RESET;
        end else if (wr_i) begin
            case (addr_i)
                ADDR_CTRL_A: ctrl_a <= wdata_i;
                ADDR_CTRL_B: ctrl_b <= {2'b00, wdata_i[5:0]}; // R11
                ADDR_CMP_A: cmp_a_buf <= wdata_i;
                ADDR_CMP_B: cmp_b_buf <= wdata_i;
                default: ;
            endcase
        end
    end

    // PWM modes latch the buffers at TOP so a period never sees a half update
    always_ff @(posedge clk_i or negedge reset_n_i) begin // R10
        if (!reset_n_i) begin
            cmp_a_act <= CMP_RESET;
            cmp_b_act <= CMP_RESET;
        end else if (!is_pwm || (tick && at_top)) begin
            cmp_a_act <= cmp_a_buf;
            cmp_b_act <= cmp_b_buf;
        end
    end

    // waveform: returns the new output level for one channel
    function automatic logic wave(input logic cur, input logic [1:0] com, input logic mt,
                                  input logic frc, input logic [7:0] cmpv);
        logic r;
        logic top_hit;
        r = cur;
        top_hit = tick && at_top;
        if (!is_pwm) begin
            if (mt || frc) begin // R2
                case (com)
                    2'h1: r = ~cur;
                    2'h2: r = 1'b0;
                    2'h3: r = 1'b1;
                    default: r = cur;
                endcase
            end
        end else if (com[1]) begin
            if (cmpv == top) begin
                // match ignored; level forced at TOP
                if (top_hit) begin // R5
                    r = is_fast ? ~com[0] : com[0];
                end
            end else if (is_fast) begin // R3
                if (mt) begin
                    r = com[0];
                end else if (top_hit) begin
                    r = ~com[0];
                end
            end else if (mt) begin // R4
                r = count_down ? ~com[0] : com[0];
            end
        end
        return r;
    endfunction

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_a <= 1'b0;
            out_b <= 1'b0;
        end else begin
            out_a <= wave(out_a, com_a, match_a, force_a, cmp_a_act);
            out_b <= wave(out_b, com_b, match_b, force_b, cmp_b_act);
        end
    end

    // flags: hardware set wins over clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin // R12 R20
        if (!reset_n_i) begin
            flag_a <= 1'b0;
            flag_b <= 1'b0;
            flag_ovf <= 1'b0;
        end else begin
            if (match_a) begin
                flag_a <= 1'b1;
            end else if (cmp_a_vector_ack_i ||
                         (wr_i && addr_i == ADDR_FLAGS && wdata_i[FL_CMP_A_POS])) begin
                flag_a <= 1'b0;
            end
            if (match_b) begin
                flag_b <= 1'b1;
            end else if (cmp_b_vector_ack_i ||
                         (wr_i && addr_i == ADDR_FLAGS && wdata_i[FL_CMP_B_POS])) begin
                flag_b <= 1'b0;
            end
            if (ovf_event) begin
                flag_ovf <= 1'b1;
            end else if (ovf_vector_ack_i ||
                         (wr_i && addr_i == ADDR_FLAGS && wdata_i[FL_OVF_POS])) begin
                flag_ovf <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin // R6
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_CTRL_A: rdata_o <= {ctrl_a[7:4], 2'b00, ctrl_a[1:0]};
                ADDR_CTRL_B: rdata_o <= {4'h0, ctrl_b[3:0]};
                ADDR_COUNTER: rdata_o <= count;
                ADDR_CMP_A: rdata_o <= cmp_a_buf;
                ADDR_CMP_B: rdata_o <= cmp_b_buf;
                ADDR_FLAGS: rdata_o <= {5'h00, flag_a, flag_b, flag_ovf};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // channel a: reserved code 1 in PWM modes leaves the pin with the port
    assign cmp_a_override_o = (com_a != 2'h0) && !(is_pwm && com_a == 2'h1);
    // channel b takes the pin for any nonzero code; reserved code 1 only holds the level
    assign cmp_b_override_o = (com_b != 2'h0); // R1
    assign cmp_a_out_o = out_a;
    assign cmp_b_out_o = out_b;
    assign cmp_a_pin_oe_n_o = ~(cmp_a_override_o & cmp_a_dir_i);
    assign cmp_b_pin_oe_n_o = ~(cmp_b_override_o & cmp_b_dir_i); // R1
    assign cmp_a_flag_o = flag_a;
    assign cmp_b_flag_o = flag_b;
    assign overflow_flag_o = flag_ovf;
endmodule // tmr_core

// ### tmr_core_monitor.sv
module tmr_core_monitor
    import tmr_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [tmr_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic cmp_a_dir_i,
    input wire logic cmp_b_dir_i,
    input wire logic cmp_b_vector_ack_i,
    input wire logic ovf_vector_ack_i,
    input wire logic cmp_a_pin_oe_n_o,
    input wire logic cmp_a_override_o,
    input wire logic cmp_b_pin_oe_n_o,
    input wire logic cmp_b_override_o,
    input wire logic cmp_b_flag_o,
    input wire logic overflow_flag_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking mon_cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    pin_b_drive_a: assert property (cmp_b_pin_oe_n_o == !(cmp_b_override_o && cmp_b_dir_i))
        else $error("pin b driver enable wrong");
    pin_a_drive_a: assert property (cmp_a_pin_oe_n_o == !(cmp_a_override_o && cmp_a_dir_i))
        else $error("pin a driver enable wrong");
    override_b_a: assert property (wr_i && addr_i == ADDR_CTRL_A |=>
        cmp_b_override_o == (|$past(wdata_i[5:4]))) else $error("override b wrong");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside answer cycle");
    ctrl_a_res_a: assert property (rd_i && addr_i == ADDR_CTRL_A |=> rdata_o[3:2] == 2'h0)
        else $error("control a reserved bits nonzero");
    ctrl_b_res_a: assert property (rd_i && addr_i == ADDR_CTRL_B |=> rdata_o[7:4] == 4'h0)
        else $error("control b strobe or reserved bits nonzero");
    ctrl_b_back_a: assert property (wr_i && addr_i == ADDR_CTRL_B ##1 !wr_i
        ##1 rd_i && addr_i == ADDR_CTRL_B |=> rdata_o == {4'h0, $past(wdata_i[3:0], 3)})
        else $error("control b readback wrong");
    flag_b_clr_a: assert property ($fell(cmp_b_flag_o) |-> $past(cmp_b_vector_ack_i
        || (wr_i && addr_i == ADDR_FLAGS && wdata_i[FL_CMP_B_POS]))) else $error("flag b lost");
    ovf_clr_a: assert property ($fell(overflow_flag_o) |-> $past(ovf_vector_ack_i
        || (wr_i && addr_i == ADDR_FLAGS && wdata_i[FL_OVF_POS]))) else $error("overflow lost");
endmodule // tmr_core_monitor

bind tmr_core tmr_core_monitor i_tmr_core_monitor (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cmp_a_dir_i(cmp_a_dir_i), .cmp_b_dir_i(cmp_b_dir_i), .cmp_b_vector_ack_i(cmp_b_vector_ack_i),
    .ovf_vector_ack_i(ovf_vector_ack_i), .cmp_a_pin_oe_n_o(cmp_a_pin_oe_n_o),
    .cmp_a_override_o(cmp_a_override_o), .cmp_b_pin_oe_n_o(cmp_b_pin_oe_n_o),
    .cmp_b_override_o(cmp_b_override_o), .cmp_b_flag_o(cmp_b_flag_o),
    .overflow_flag_o(overflow_flag_o));

// ### tmr_pkg.sv
package tmr_pkg;
    // register indices on the plain register port
    localparam logic [2:0] ADDR_CTRL_A = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B = 3'h1;
    localparam logic [2:0] ADDR_COUNTER = 3'h2;
    localparam logic [2:0] ADDR_CMP_A = 3'h3;
    localparam logic [2:0] ADDR_CMP_B = 3'h4;
    localparam logic [2:0] ADDR_FLAGS = 3'h5;
    localparam int ADDR_W = 3;

    // control a fields
    localparam int CA_COM_A_POS = 6;
    localparam int CA_COM_B_POS = 4;
    localparam int CA_WGM_LO_POS = 0;
    // control b fields
    localparam int CB_FOC_A_POS = 7;
    localparam int CB_FOC_B_POS = 6;
    localparam int CB_WGM_HI_POS = 3;
    localparam int CB_CS_POS = 0;
    // flag register fields (write one to clear)
    localparam int FL_CMP_A_POS = 2;
    localparam int FL_CMP_B_POS = 1;
    localparam int FL_OVF_POS = 0;

    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [7:0] VAL_MAX = 8'hff;
    localparam logic [7:0] VAL_BOTTOM = 8'h00;

    // prescaler taps, in I/O clock cycles
    localparam int DIV_8 = 8;
    localparam int DIV_64 = 64;
    localparam int DIV_256 = 256;
    localparam int DIV_1024 = 1024;
    localparam int PRESC_W = 10;

    typedef enum logic [2:0] {
        CS_STOP = 3'h0,
        CS_DIV1 = 3'h1,
        CS_DIV8 = 3'h2,
        CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4,
        CS_DIV1024 = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } tmr_clk_sel_t;

    typedef enum logic [2:0] {
        WM_NORMAL = 3'h0,
        WM_PC_FF = 3'h1,
        WM_CTC = 3'h2,
        WM_FAST_FF = 3'h3,
        WM_RES4 = 3'h4,
        WM_PC_OCRA = 3'h5,
        WM_RES6 = 3'h6,
        WM_FAST_OCRA = 3'h7
    } tmr_wave_mode_t;
endpackage
